// >>> rtl/cfgpc_pkg.sv
// Shared constants, types and register map of the configuration pin control.
package cfgpc_pkg;

  // Clock rates and the internal configuration oscillator.
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned OSC_FAST_HZ = 10_000_000;
  localparam int unsigned OSC_SLOW_HZ = 1_250_000;
  // Half periods round down so the strobe is never slower than asked.
  localparam int unsigned FAST_HALF = CLK_HZ / (2 * OSC_FAST_HZ);
  localparam int unsigned SLOW_HALF = CLK_HZ / (2 * OSC_SLOW_HZ);
  localparam logic [7:0] FAST_HALF_CNT = 8'(FAST_HALF - 1);
  localparam logic [7:0] SLOW_HALF_CNT = 8'(SLOW_HALF - 1);

  // Cycles during which the initialization line is held low after restart.
  localparam logic [15:0] INIT_CLEAR_CYCLES = 16'h0100;

  // Register byte offsets on the Wishbone port.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LENGTH = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0c;

  // Values after reset.
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [23:0] LENGTH_RESET = 24'h000000;

  // Sequencer states.
  typedef enum logic [4:0] {
    ST_CLEAR = 5'h01,
    ST_WAIT = 5'h02,
    ST_LOAD = 5'h04,
    ST_STARTUP = 5'h08,
    ST_USER = 5'h10
  } cfgpc_state_type;

  // Loading modes.
  typedef enum logic [5:0] {
    MD_MSER = 6'h01,
    MD_SSER = 6'h02,
    MD_MPAR = 6'h04,
    MD_SPAR = 6'h08,
    MD_APER = 6'h10,
    MD_SPER = 6'h20
  } cfgpc_mode_type;

  // Pin inputs from outside the clock domain.
  typedef struct packed {
    logic config_reset;
    logic program_restart_n;
    logic readback_trigger_n;
    logic [2:0] mode_bits;
    logic osc_speed_select;
    logic config_clock;
    logic done_n;
    logic init_n;
    logic select_low_active_n;
    logic select_high_active;
    logic write_n;
    logic read_n;
    logic [7:0] data;
  } cfgpc_pins_type;

  localparam int unsigned PIN_W = $bits(cfgpc_pins_type);
  // Idle level of every pin: restart inputs inactive, strobes high, clock
  // low, host deselected, so no false edge or restart follows reset.
  localparam logic [21:0] PIN_IDLE = 22'h1fbbff;

  // Control register fields.
  typedef struct packed {
    logic ts_after_cfg;
    logic reset_to_cells;
    logic scan_used;
    logic readback_en;
  } cfgpc_ctrl_type;

endpackage : cfgpc_pkg

// >>> rtl/cfgpc_top.sv
// Configuration pin control: restart, mode selection, loading and readback.
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module cfgpc_top
  import cfgpc_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int FRAME_W = 32,
  parameter int FRAME_ADDR_W = 8,
  parameter logic [7:0] RB_FRAMES = 8'h10,
  parameter logic [2:0] MODE_CODE_MSER = 3'h0,
  parameter logic [2:0] MODE_CODE_SSER = 3'h7,
  parameter logic [2:0] MODE_CODE_MPAR = 3'h4,
  parameter logic [2:0] MODE_CODE_SPAR = 3'h3,
  parameter logic [2:0] MODE_CODE_APER = 3'h5,
  parameter logic [2:0] MODE_CODE_SPER = 3'h6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic config_reset_i,
  input wire logic program_restart_n_i,
  input wire logic readback_trigger_n_i,
  input wire logic mode_select_bit0_i,
  input wire logic mode_select_bit1_i,
  input wire logic mode_select_bit2_i,
  input wire logic osc_speed_select_i,
  input wire logic config_clock_i,
  output logic config_clock_o,
  output logic config_clock_oe_o,
  input wire logic done_n_i,
  output logic done_n_o,
  output logic done_n_oe_o,
  input wire logic init_n_i,
  output logic init_n_o,
  output logic init_n_oe_o,
  input wire logic select_low_active_n_i,
  input wire logic select_high_active_i,
  input wire logic write_n_i,
  input wire logic read_n_i,
  input wire logic [7:0] data_i,
  output logic data7_o,
  output logic data7_oe_o,
  output logic ready_busy_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic mem_read_o,
  output logic cascade_out_o,
  output logic [7:0] cfg_byte_o,
  output logic cfg_byte_valid_o,
  input wire logic [FRAME_W-1:0] readback_frame_i,
  output logic [FRAME_ADDR_W-1:0] readback_addr_o,
  output logic readback_data_o,
  output logic config_active_high_o,
  output logic config_active_low_n_o,
  output logic global_tristate_o,
  output logic scan_enable_o,
  output logic scan_reset_o,
  output logic logic_cell_reset_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Maps a mode-select pattern onto a loading mode.
  function automatic cfgpc_mode_type decode_mode(input logic [2:0] bits);
    if (bits == MODE_CODE_MSER) return MD_MSER;
    if (bits == MODE_CODE_MPAR) return MD_MPAR;
    if (bits == MODE_CODE_SPAR) return MD_SPAR;
    if (bits == MODE_CODE_APER) return MD_APER;
    if (bits == MODE_CODE_SPER) return MD_SPER;
    return MD_SSER;
  endfunction : decode_mode

  // Word address match of a bus access.
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
    return {a[7:2], 2'b00} == o;
  endfunction : reg_hit

  cfgpc_pins_type pin_raw;
  cfgpc_pins_type pin_f;
  logic [PIN_W-1:0] sync1_r, sync2_r, sync3_r, filt_r;
  cfgpc_state_type state_r;
  cfgpc_mode_type mode_r;
  cfgpc_ctrl_type ctrl_r;
  logic [23:0] length_r, byte_count_r;
  logic [15:0] clear_cnt_r;
  logic [7:0] div_cnt_r, shift_r, buf_r;
  logic [2:0] bit_cnt_r;
  logic osc_lvl_r, clk_pin_prev_r, wr_prev_r, trig_prev_r;
  logic buf_full_r, last_bit_r, ack_r;
  logic rb_active_r;
  logic [$clog2(FRAME_W)-1:0] rb_bit_r;
  logic [FRAME_ADDR_W-1:0] rb_addr_r;
  logic tick_rise, tick_fall, ext_rise, clk_rise, clk_fall;
  logic dev_clk_mode, selected, loading, wr_fall, take_byte, rb_start;
  logic [7:0] new_byte;
  logic last_byte;

  // Gather pins into one carrier for the synchronisers.
  assign pin_raw = '{config_reset_i, program_restart_n_i,
    readback_trigger_n_i, {mode_select_bit2_i, mode_select_bit1_i,
    mode_select_bit0_i}, osc_speed_select_i, config_clock_i, done_n_i,
    init_n_i, select_low_active_n_i, select_high_active_i, write_n_i,
    read_n_i, data_i};

  // Three-stage synchroniser; a change counts once stages two and three agree.
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_r[g] <= PIN_IDLE[g];
          sync2_r[g] <= PIN_IDLE[g];
          sync3_r[g] <= PIN_IDLE[g];
          filt_r[g] <= PIN_IDLE[g];
        end else begin
          sync1_r[g] <= pin_raw[g];
          sync2_r[g] <= sync1_r[g];
          sync3_r[g] <= sync2_r[g];
          if (sync2_r[g] == sync3_r[g]) begin
            filt_r[g] <= sync3_r[g];
          end
        end
      end
    end
  endgenerate
  assign pin_f = filt_r;

  // Oscillator divider; its half period follows the speed select pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r <= FAST_HALF_CNT;
      osc_lvl_r <= 1'b0;
    end else if (div_cnt_r == 8'h00) begin
      div_cnt_r <= pin_f.osc_speed_select ? SLOW_HALF_CNT
                                          : FAST_HALF_CNT;
      osc_lvl_r <= ~osc_lvl_r;
    end else begin
      div_cnt_r <= div_cnt_r - 8'h01;
    end
  end
  assign tick_rise = (div_cnt_r == 8'h00) && !osc_lvl_r;
  assign tick_fall = (div_cnt_r == 8'h00) && osc_lvl_r;

  // Edge history of the strobes seen on pins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_pin_prev_r <= 1'b0;
      wr_prev_r <= 1'b1;
      trig_prev_r <= 1'b1;
    end else begin
      clk_pin_prev_r <= pin_f.config_clock;
      wr_prev_r <= pin_f.write_n;
      trig_prev_r <= pin_f.readback_trigger_n;
    end
  end

  // Clock source choice and selection qualifiers.
  assign dev_clk_mode = (mode_r == MD_MSER) || (mode_r == MD_MPAR) ||
                        (mode_r == MD_APER);
  assign ext_rise = pin_f.config_clock && !clk_pin_prev_r;
  assign clk_rise = dev_clk_mode ? tick_rise : ext_rise;
  assign clk_fall = dev_clk_mode ? tick_fall
                                 : (!pin_f.config_clock && clk_pin_prev_r);
  assign selected = !pin_f.select_low_active_n && pin_f.select_high_active;
  assign loading = (state_r == ST_LOAD);
  assign wr_fall = !pin_f.write_n && wr_prev_r;

  // Byte arrival per mode.
  always_comb begin
    take_byte = 1'b0;
    new_byte = pin_f.data;
    unique case (mode_r)
      MD_MSER, MD_SSER: begin
        take_byte = clk_rise && (bit_cnt_r == 3'h7);
        new_byte = {shift_r[6:0], pin_f.data[0]};
      end
      MD_MPAR: take_byte = clk_rise;
      MD_SPAR, MD_SPER: begin
        take_byte = clk_rise && selected && !pin_f.write_n;
      end
      MD_APER: begin
        take_byte = tick_rise && buf_full_r;
        new_byte = buf_r;
      end
    endcase
    take_byte = take_byte && loading;
  end
  assign last_byte = (length_r != 24'h000000) &&
                     (byte_count_r + 24'h000001 >= length_r);

  // Sequencer from restart through loading to user operation.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_CLEAR;
      clear_cnt_r <= 16'h0000;
      mode_r <= MD_SSER;
    end else if (!pin_f.program_restart_n) begin
      state_r <= ST_CLEAR;
      clear_cnt_r <= 16'h0000;
    end else begin
      unique case (state_r)
        ST_CLEAR: begin
          clear_cnt_r <= clear_cnt_r + 16'h0001;
          if (clear_cnt_r == INIT_CLEAR_CYCLES - 16'h0001) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          clear_cnt_r <= 16'h0000;
          if (pin_f.config_reset) begin
            state_r <= ST_CLEAR;
          end else if (pin_f.init_n) begin
            state_r <= ST_LOAD;
            mode_r <= decode_mode(pin_f.mode_bits);
          end
        end
        ST_LOAD: begin
          if (pin_f.config_reset) begin
            state_r <= ST_CLEAR;
          end else if (take_byte && last_byte) begin
            state_r <= ST_STARTUP;
          end
        end
        ST_STARTUP: begin
          if (pin_f.done_n) begin
            state_r <= ST_USER;
          end
        end
        ST_USER: state_r <= ST_USER;
      endcase
    end
  end

  // Serial shift, peripheral buffer, byte counting and cascade data.
  always_ff @(posedge clk_i) begin
    if (rst_i || !loading) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      buf_r <= 8'h00;
      buf_full_r <= 1'b0;
      last_bit_r <= 1'b0;
      cfg_byte_o <= 8'h00;
      cfg_byte_valid_o <= 1'b0;
      if (rst_i || state_r == ST_CLEAR) begin
        byte_count_r <= 24'h000000;
      end
    end else begin
      cfg_byte_valid_o <= take_byte;
      if (clk_rise) begin
        shift_r <= {shift_r[6:0], pin_f.data[0]};
        bit_cnt_r <= bit_cnt_r + 3'h1;
        last_bit_r <= pin_f.data[0];
      end
      if (mode_r == MD_APER && selected && wr_fall) begin
        buf_r <= pin_f.data;
        buf_full_r <= 1'b1;
      end else if (take_byte && mode_r == MD_APER) begin
        buf_full_r <= 1'b0;
      end
      if (take_byte) begin
        cfg_byte_o <= new_byte;
        byte_count_r <= byte_count_r + 24'h000001;
      end
    end
  end

  // Pin outputs that must come from flip-flops.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cascade_out_o <= 1'b0;
      mem_addr_o <= '0;
      mem_read_o <= 1'b0;
      data7_o <= 1'b0;
    end else begin
      if (loading && clk_fall) begin
        cascade_out_o <= last_bit_r;
      end
      if (!loading) begin
        mem_addr_o <= '0;
        mem_read_o <= 1'b0;
      end else if (mode_r == MD_MPAR) begin
        if (clk_fall) begin
          mem_read_o <= 1'b1;
        end else if (clk_rise) begin
          mem_read_o <= 1'b0;
          mem_addr_o <= mem_addr_o + 1'b1;
        end
      end
      data7_o <= !buf_full_r;
    end
  end

  // Readback shifts frames out from address zero on the oscillator.
  assign rb_start = (state_r == ST_USER) && ctrl_r.readback_en &&
                    !pin_f.readback_trigger_n && trig_prev_r && !rb_active_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r != ST_USER) begin
      rb_active_r <= 1'b0;
      rb_bit_r <= '0;
      rb_addr_r <= '0;
      readback_data_o <= 1'b0;
    end else if (rb_start) begin
      rb_active_r <= 1'b1;
      rb_bit_r <= '0;
      rb_addr_r <= '0;
    end else if (rb_active_r && tick_rise) begin
      readback_data_o <= readback_frame_i[rb_bit_r];
      rb_bit_r <= rb_bit_r + 1'b1;
      if (rb_bit_r == $bits(rb_bit_r)'(FRAME_W - 1)) begin
        rb_addr_r <= rb_addr_r + 1'b1;
        if (rb_addr_r == FRAME_ADDR_W'(RB_FRAMES - 8'h01)) begin
          rb_active_r <= 1'b0;
        end
      end
    end
  end
  assign readback_addr_o = rb_addr_r;

  // Wishbone slave: one wait state, unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      ctrl_r <= CTRL_RESET;
      length_r <= LENGTH_RESET;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      if (wb_cyc_i && wb_stb_i && !ack_r) begin
        wb_dat_o <= 32'h00000000;
        if (wb_we_i && reg_hit(wb_adr_i, REG_CTRL) && wb_sel_i[0]) begin
          ctrl_r <= wb_dat_i[3:0];
        end
        if (wb_we_i && reg_hit(wb_adr_i, REG_LENGTH)) begin
          for (int i = 0; i < 3; i++) begin
            if (wb_sel_i[i]) begin
              length_r[8*i +: 8] <= wb_dat_i[8*i +: 8];
            end
          end
        end
        if (!wb_we_i && reg_hit(wb_adr_i, REG_CTRL)) begin
          wb_dat_o <= {28'h0000000, ctrl_r};
        end
        if (!wb_we_i && reg_hit(wb_adr_i, REG_LENGTH)) begin
          wb_dat_o <= {8'h00, length_r};
        end
        if (!wb_we_i && reg_hit(wb_adr_i, REG_STATUS)) begin
          wb_dat_o <= {17'h00000, pin_f.done_n, pin_f.init_n, buf_full_r,
                       rb_active_r, mode_r, state_r};
        end
        if (!wb_we_i && reg_hit(wb_adr_i, REG_COUNT)) begin
          wb_dat_o <= {8'h00, byte_count_r};
        end
      end
    end
  end
  assign wb_ack_o = ack_r;

  // Configuration clock drive and open-drain status lines.
  assign config_clock_o = osc_lvl_r;
  assign config_clock_oe_o = loading && dev_clk_mode;
  assign done_n_o = 1'b0;
  assign done_n_oe_o = (state_r != ST_STARTUP) &&
                       (state_r != ST_USER);
  assign init_n_o = 1'b0;
  assign init_n_oe_o = (state_r == ST_CLEAR);
  assign data7_oe_o = loading && (mode_r == MD_APER) && selected &&
                      !pin_f.read_n && pin_f.write_n;
  assign ready_busy_o = loading && ((mode_r == MD_APER) ||
                        (mode_r == MD_SPER)) && !buf_full_r;

  // Global controls derived from the sequencer state, the control register and pins.
  assign config_active_high_o = (state_r != ST_USER);
  assign config_active_low_n_o = (state_r == ST_USER);
  assign global_tristate_o = !pin_f.readback_trigger_n &&
    ((state_r != ST_USER) || ctrl_r.ts_after_cfg);
  assign scan_enable_o = (state_r != ST_USER) || ctrl_r.scan_used;
  assign scan_reset_o = !pin_f.program_restart_n;
  assign logic_cell_reset_o = (state_r == ST_USER) &&
    ctrl_r.reset_to_cells && pin_f.config_reset;

  // Checks kept beside the logic they guard.
  a_reset_abort: assert property (loading && pin_f.config_reset &&
    pin_f.program_restart_n |=> state_r == ST_CLEAR)
    else $error("reset input did not abort the load");
  a_program_restart: assert property (!pin_f.program_restart_n |->
    scan_reset_o ##1 state_r == ST_CLEAR)
    else $error("program input did not restart configuration");
  a_done_held: assert property (state_r inside {ST_CLEAR, ST_WAIT, ST_LOAD}
    |-> done_n_oe_o && !done_n_o)
    else $error("done line released before completion");
  a_startup_waits: assert property (state_r == ST_STARTUP &&
    !pin_f.done_n && pin_f.program_restart_n |=>
    state_r == ST_STARTUP)
    else $error("start-up did not wait for done line");
  a_init_clear_low: assert property (state_r == ST_CLEAR |->
    init_n_oe_o && !init_n_o)
    else $error("init line not driven low while clearing");
  a_wait_hold: assert property (state_r == ST_WAIT && !pin_f.init_n |=>
    state_r != ST_LOAD)
    else $error("load began while init held low");
  a_cfg_flags: assert property (state_r != ST_USER |->
    config_active_high_o && !config_active_low_n_o)
    else $error("config active outputs wrong before completion");
  a_write_prio: assert property (!pin_f.write_n && !pin_f.read_n |->
    !data7_oe_o)
    else $error("status driven during write strobe");
  a_load_tristate: assert property (loading &&
    !pin_f.readback_trigger_n |-> global_tristate_o)
    else $error("trigger low did not tristate during load");
  a_fast_period: assert property (tick_rise && !pin_f.osc_speed_select
    |=> !tick_rise [*8])
    else $error("fast oscillator period too short");
  a_rb_start: assert property (rb_start |=> rb_active_r &&
    readback_addr_o == '0)
    else $error("readback did not start at frame zero");
  a_cascade_fall: assert property ($changed(cascade_out_o) |->
    $past(clk_fall))
    else $error("cascade output changed off a falling clock");
  a_mpar_addr: assert property (loading && mode_r == MD_MPAR && clk_rise
    && !pin_f.config_reset |=> mem_addr_o == $past(mem_addr_o) + 1'b1)
    else $error("memory address did not advance");

endmodule : cfgpc_top

// >>> tb/cfgpc_board_model.sv
// Board-side model: open-drain wires with pull-ups and the host's clock.
`timescale 1ns/1ps
module cfgpc_board_model (
  input wire logic done_oe_i,
  input wire logic init_oe_i,
  input wire logic hold_done_i,
  input wire logic hold_init_i,
  input wire logic run_clock_i,
  output logic done_n_o,
  output logic init_n_o,
  output logic config_clock_o
);
  // Each wire reads low while any party pulls it, else the pull-up wins.
  assign done_n_o = !(done_oe_i || hold_done_i);
  assign init_n_o = !(init_oe_i || hold_init_i);
  // The board straps test mode select high for the whole load; the block
  // has no test mode select input, so the strap lives here as a board constant.
  localparam logic TEST_MODE_SEL_LEVEL = 1'b1;
  // Host clock of 80 ns, out of phase with clk_i and parked low when idle.
  initial begin
    config_clock_o = 1'b0;
    #3;
    forever begin
      #40;
      config_clock_o = run_clock_i ? !config_clock_o : 1'b0;
    end
  end
endmodule : cfgpc_board_model

// >>> tb/testbench.sv
// Testbench of the configuration pin control, driven through its pins.
`timescale 1ns/1ps
module testbench;
  import cfgpc_pkg::*;
  localparam logic [2:0] CODE [6] = '{3'h0, 3'h7, 3'h4, 3'h3, 3'h5, 3'h6};
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [7:0] wb_adr_i, data_i, cfg_byte_o, readback_addr_o;
  logic [31:0] wb_dat_i, wb_dat_o, readback_frame_i, q;
  logic [3:0] wb_sel_i;
  logic config_reset_i, program_restart_n_i, readback_trigger_n_i;
  logic mode_select_bit0_i, mode_select_bit1_i, mode_select_bit2_i;
  logic osc_speed_select_i, config_clock_i, config_clock_o;
  logic config_clock_oe_o, done_n_i, done_n_o, done_n_oe_o, init_n_i;
  logic init_n_o, init_n_oe_o, select_low_active_n_i, select_high_active_i;
  logic write_n_i, read_n_i, data7_o, data7_oe_o, ready_busy_o, mem_read_o;
  logic [17:0] mem_addr_o, addr0;
  logic cascade_out_o, cfg_byte_valid_o, readback_data_o;
  logic config_active_high_o, config_active_low_n_o, global_tristate_o;
  logic scan_enable_o, scan_reset_o, logic_cell_reset_o;
  logic hold_done, hold_init, run_clk;
  int n_mismatch, checked, p;

  cfgpc_top DUT (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .config_reset_i,
    .program_restart_n_i, .readback_trigger_n_i, .mode_select_bit0_i,
    .mode_select_bit1_i, .mode_select_bit2_i, .osc_speed_select_i,
    .config_clock_i, .config_clock_o, .config_clock_oe_o, .done_n_i,
    .done_n_o, .done_n_oe_o, .init_n_i, .init_n_o, .init_n_oe_o,
    .select_low_active_n_i, .select_high_active_i, .write_n_i, .read_n_i,
    .data_i, .data7_o, .data7_oe_o, .ready_busy_o, .mem_addr_o, .mem_read_o,
    .cascade_out_o, .cfg_byte_o, .cfg_byte_valid_o, .readback_frame_i,
    .readback_addr_o, .readback_data_o, .config_active_high_o,
    .config_active_low_n_o, .global_tristate_o, .scan_enable_o,
    .scan_reset_o, .logic_cell_reset_o);

  cfgpc_board_model board (.done_oe_i(done_n_oe_o), .init_oe_i(init_n_oe_o),
    .hold_done_i(hold_done), .hold_init_i(hold_init), .run_clock_i(run_clk),
    .done_n_o(done_n_i), .init_n_o(init_n_i), .config_clock_o(config_clock_i));

  // System clock of 8 ns.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = !clk_i;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    chk(n < 40, 1'b1, "bus answer");
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Polls the state field until the given one-hot bit shows.
  task automatic wait_st(input int b);
    logic [31:0] s;
    s = '0;
    for (int i = 0; i < 300 && s[b] !== 1'b1; i++) wb(1'b0, REG_STATUS, '0, s);
    chk(s[b], 1'b1, "state reached");
  endtask : wait_st

  // Restarts loading in the given mode and waits for the load state.
  task automatic restart(input logic [2:0] m);
    {mode_select_bit2_i, mode_select_bit1_i, mode_select_bit0_i} <= m;
    program_restart_n_i <= 1'b0;
    tick(8);
    chk(scan_reset_o, 1'b1, "scan reset");
    chk(init_n_oe_o, 1'b1, "init pulled");
    program_restart_n_i <= 1'b1;
    wait_st(2);
  endtask : restart

  // Measures one period of the device clock in system cycles.
  task automatic period(output int c);
    realtime t0;
    @(posedge config_clock_o);
    t0 = $realtime;
    @(posedge config_clock_o);
    c = int'(($realtime - t0) / 8.0);
  endtask : period

  // Peripheral byte write; rd also pulls the read strobe at the same time.
  task automatic pwrite(input logic [7:0] d, input logic rd);
    logic got;
    logic [7:0] v;
    got = 1'b0;
    v = 8'h00;
    data_i <= d;
    write_n_i <= 1'b0;
    read_n_i <= !rd;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_i);
      if (i == 6 && rd) chk(data7_oe_o, 1'b0, "write wins");
      if (i == 6) write_n_i <= 1'b1;
      if (i == 6) read_n_i <= 1'b1;
      // The byte output clears once loading ends, so take it with its pulse.
      if (cfg_byte_valid_o === 1'b1) begin
        got = 1'b1;
        v = cfg_byte_o;
      end
    end
    chk(got, 1'b1, "byte pulse");
    chk(v, d, "byte value");
  endtask : pwrite

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Watchdog sized well above the sequence below.
  initial begin
    #600000;
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {rst_i, hold_init} = 2'b11;
    {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
    {wb_sel_i, config_reset_i, program_restart_n_i} = 6'h3d;
    {readback_trigger_n_i, osc_speed_select_i, hold_done, run_clk} = 4'h8;
    {mode_select_bit2_i, mode_select_bit1_i, mode_select_bit0_i} = 3'h0;
    {select_low_active_n_i, select_high_active_i} = 2'b10;
    {write_n_i, read_n_i, data_i} = 10'h3ff;
    readback_frame_i = 32'h5a5a_0ff0;
    n_mismatch = 0;
    checked = 0;
    tick(6);
    rst_i <= 1'b0;
    tick(2);
    chk(config_active_high_o, 1'b1, "busy high");
    chk(config_active_low_n_o, 1'b0, "busy low");
    chk(done_n_oe_o, 1'b1, "done pulled");
    chk({done_n_o, init_n_o}, 2'b00, "open drain low");
    wb(1'b0, REG_CTRL, '0, q);
    chk(q, 32'h0, "ctrl reset");
    wb(1'b0, 8'h10, '0, q);
    chk(q, 32'h0, "unmapped read");
    tick(400);
    wb(1'b0, REG_STATUS, '0, q);
    chk(q[4:0], 5'h02, "held in wait");
    hold_init <= 1'b0;
    wait_st(2);
    $display("end of reset and wait test");
    for (int i = 0; i < 6; i++) begin
      run_clk <= (i % 2) == 1;
      restart(CODE[i]);
      wb(1'b0, REG_STATUS, '0, q);
      chk(q[10:5], 6'h01 << i, "mode");
      chk(config_clock_oe_o, i % 2 == 0, "clock owner");
    end
    run_clk <= 1'b0;
    data_i <= 8'hfe;
    restart(CODE[0]);
    period(p);
    chk(p, 2 * FAST_HALF, "fast clock");
    chk(cascade_out_o, 1'b0, "cascade low");
    data_i <= 8'hff;
    osc_speed_select_i <= 1'b1;
    restart(CODE[0]);
    period(p);
    chk(p, 2 * SLOW_HALF, "slow clock");
    chk(cascade_out_o, 1'b1, "cascade high");
    osc_speed_select_i <= 1'b0;
    // Master parallel: strobe high in the low half, address steps on rise.
    restart(CODE[2]);
    @(posedge config_clock_o);
    tick(3);
    chk(mem_read_o, 1'b0, "read strobe idle");
    addr0 = mem_addr_o;
    @(negedge config_clock_o);
    tick(3);
    chk(mem_read_o, 1'b1, "read strobe");
    @(posedge config_clock_o);
    tick(3);
    chk(mem_addr_o, addr0 + 18'h00001, "address step");
    config_reset_i <= 1'b1;
    tick(8);
    chk(init_n_oe_o, 1'b1, "reset restarts");
    config_reset_i <= 1'b0;
    $display("end of mode test");
    wb(1'b1, REG_LENGTH, 32'h0000_0002, q);
    wb(1'b0, REG_LENGTH, '0, q);
    chk(q, 32'h2, "length");
    restart(CODE[4]);
    readback_trigger_n_i <= 1'b0;
    tick(8);
    chk(global_tristate_o, 1'b1, "tristate");
    readback_trigger_n_i <= 1'b1;
    {select_low_active_n_i, select_high_active_i} <= 2'b01;
    read_n_i <= 1'b0;
    tick(8);
    chk({data7_oe_o, data7_o, ready_busy_o}, 3'h7, "ready");
    pwrite(8'ha5, 1'b0);
    hold_done <= 1'b1;
    pwrite(8'h5a, 1'b1);
    tick(20);
    chk(done_n_oe_o, 1'b0, "done freed");
    wb(1'b0, REG_STATUS, '0, q);
    chk(q[4:0], 5'h08, "start-up held");
    hold_done <= 1'b0;
    wait_st(4);
    chk({config_active_high_o, config_active_low_n_o}, 2'b01, "ended");
    chk(scan_enable_o, 1'b0, "scan off");
    wb(1'b0, REG_COUNT, '0, q);
    chk(q, 32'h2, "count");
    $display("end of peripheral test");
    wb(1'b1, REG_CTRL, 32'h5, q);
    config_reset_i <= 1'b1;
    tick(8);
    chk(logic_cell_reset_o, 1'b1, "cell reset");
    config_reset_i <= 1'b0;
    readback_trigger_n_i <= 1'b0;
    tick(8);
    wb(1'b0, REG_STATUS, '0, q);
    chk(q[11], 1'b1, "readback");
    chk(q[4], 1'b1, "still user");
    readback_trigger_n_i <= 1'b1;
    // Frame 1 comes out LSB first, one bit per device clock rise.
    wait (readback_addr_o == 8'h01);
    @(negedge config_clock_o);
    for (int i = 0; i < 32; i++) begin
      @(negedge config_clock_o);
      q[i] = readback_data_o;
    end
    chk(q, 32'h5a5a_0ff0, "readback frame");
    chk(readback_addr_o, 8'h02, "frame address");
    $display("end of user test");
    report_and_stop();
  end
endmodule : testbench
